/* File: rtl/wdp_pkg.sv */
package wdp_pkg;

   // Bus geometry
   localparam int unsigned AXI_ADDR_W = 8;
   localparam int unsigned AXI_DATA_W = 32;

   // Register byte offsets
   localparam logic [7:0] REG_WDT_CTRL  = 8'h00;
   localparam logic [7:0] REG_OPTION    = 8'h04;
   localparam logic [7:0] REG_COUNT     = 8'h08;
   localparam logic [7:0] REG_IRQ_STAT  = 8'h0C;
   localparam logic [7:0] REG_IRQ_MASK  = 8'h10;
   localparam logic [7:0] REG_OSC_STAT  = 8'h14;

   // Bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Timing: system clock and nominal low-frequency oscillator rate
   localparam int unsigned CLK_FREQ_HZ    = 200_000_000;
   localparam int unsigned LFOSC_FREQ_HZ  = 31_000;
   localparam int unsigned LF_DIV_CYCLES  = CLK_FREQ_HZ / LFOSC_FREQ_HZ;
   localparam int unsigned LF_DIV_W       = 13;

   // Prescaler geometry: ratio is 32 shifted left by the select code
   localparam int unsigned PRE_W          = 16;
   localparam logic [3:0]  PS_CODE_MAX    = 4'hB;
   localparam logic [PRE_W-1:0] PRE_BASE_LAST = 16'h001F;
   localparam int unsigned POST_W         = 8;

   // Watchdog control register layout
   typedef struct packed {
      logic [3:0] prescale_sel;
      logic       software_watchdog_on;
   } wdp_ctrl_s;
   localparam wdp_ctrl_s CTRL_RESET = 5'h08;
   localparam int unsigned CTRL_W   = 5;

   // Legacy option fields for the shared prescaler
   typedef struct packed {
      logic       prescaler_assign_bit;
      logic [2:0] prescale_rate_field;
   } wdp_opt_s;
   localparam wdp_opt_s OPT_RESET = 4'hF;
   localparam int unsigned OPT_W  = 4;

   // Interrupt status and mask layout
   typedef struct packed {
      logic osc_fail;
      logic wake;
      logic timeout;
   } wdp_irq_s;
   localparam int unsigned IRQ_W     = 3;
   localparam wdp_irq_s    IRQ_RESET = 3'h0;

   // Sleep exit hold state
   typedef enum logic {
      WDP_FREE,
      WDP_OST_HOLD
   } wdp_hold_e;

endpackage

/* File: rtl/wdp_prescaler.sv */
`timescale 1ns/1ps
module wdp_prescaler (
   // Clock and reset
   input  wire logic                          aclk,
   input  wire logic                          aresetn,
   // Control
   input  wire logic                          clear,
   input  wire logic                          lf_tick,
   input  wire logic [3:0]                    prescale_sel,
   // Status
   output logic      [wdp_pkg::PRE_W-1:0]     count,
   output logic                               tick
);
   import wdp_pkg::*;

   logic [PRE_W-1:0] last;

   // Terminal count for ratio 32 << code, held at 65536 above the top code
   function automatic logic [PRE_W-1:0] ratio_last(input logic [3:0] code);
      logic [3:0] c;
      c = (code > PS_CODE_MAX) ? PS_CODE_MAX : code;
      return PRE_W'((({1'b0, PRE_BASE_LAST} + 17'h00001) << c) - 17'h00001);
   endfunction

   assign last = ratio_last(prescale_sel);
   assign tick = lf_tick & (count == last) & ~clear;

   // Divide the low-frequency time base
   always_ff @(posedge aclk) begin
      if (!aresetn || clear || tick) begin
         count <= '0;
      end else if (lf_tick) begin
         count <= count + 16'h0001;
      end
   end

endmodule

/* File: rtl/wdp_watchdog.sv */
// How it works
// [RL1] The watchdog counts ticks of the 31 kHz low-frequency oscillator, made here as an enable pulse.
// [RL2] The watchdog has its own prescaler apart from the one shared with Timer0, so both scale at once.
// [RL3] That prescaler is 16 bits and divides by 32 up to 65536.
// [RL4] Every reset loads the control register with 0 1000: 16 ms time base, software enable clear.
// [RL5] The low-frequency stable flag ignores the watchdog's use of that oscillator.
// [RL6] With the configuration force-on bit set the watchdog always runs and the software bit does nothing.
// [RL7] With the force-on bit clear the software bit starts and stops the watchdog.
// [RL8] The clear-watchdog instruction and an oscillator failure clear the count.
// [RL9] Leaving sleep in a crystal clock mode holds the count cleared until the start-up timer ends.
// [RL10] The select code picks ratio 32 << code, reset code 0100 giving 1:512; timeout resets or wakes.
// [RL11] The assign bit and rate field route the shared prescaler to Timer0 or the watchdog.
`timescale 1ns/1ps
module wdp_watchdog #(
   parameter int unsigned LF_DIV = wdp_pkg::LF_DIV_CYCLES
) (
   // Clock and reset
   input  wire logic                           aclk,
   input  wire logic                           aresetn,
   // AXI4-Lite write address
   input  wire logic [wdp_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                           s_axi_awvalid,
   output logic                                s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [wdp_pkg::AXI_DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]                     s_axi_wstrb,
   input  wire logic                           s_axi_wvalid,
   output logic                                s_axi_wready,
   // AXI4-Lite write response
   output logic      [1:0]                     s_axi_bresp,
   output logic                                s_axi_bvalid,
   input  wire logic                           s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [wdp_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
   input  wire logic                           s_axi_arvalid,
   output logic                                s_axi_arready,
   // AXI4-Lite read data
   output logic      [wdp_pkg::AXI_DATA_W-1:0] s_axi_rdata,
   output logic      [1:0]                     s_axi_rresp,
   output logic                                s_axi_rvalid,
   input  wire logic                           s_axi_rready,
   // Core and clock system events
   input  wire logic                           config_watchdog_force_on,
   input  wire logic                           clear_watchdog_instr,
   input  wire logic                           osc_fail_detect,
   input  wire logic                           sleep_active,
   input  wire logic                           sleep_exit,
   input  wire logic                           sysclk_is_crystal,
   input  wire logic                           osc_startup_done,
   input  wire logic                           sysclk_on_lfosc,
   input  wire logic                           timer0_src_tick,
   // Results
   output logic                                watchdog_reset_req,
   output logic                                watchdog_wake_req,
   output logic                                timer0_scaled_tick,
   output logic                                lowfreq_stable_flag,
   output logic                                irq
);
   import wdp_pkg::*;

   // Registers
   wdp_ctrl_s                watchdog_control_reg;
   wdp_opt_s                 option_reg;
   wdp_irq_s                 irq_stat;
   wdp_irq_s                 irq_mask;
   // Time base and counting chain
   logic [LF_DIV_W-1:0]      lf_div_cnt;
   logic                     lf_run;
   logic                     lf_tick;
   logic                     wdt_enable;
   logic                     wdt_clear;
   logic                     pre_tick;
   logic [PRE_W-1:0]         pre_count;
   logic [POST_W-1:0]        shared_cnt;
   logic [POST_W-1:0]        shared_last;
   logic                     timeout_evt;
   logic                     t0_evt;
   wdp_hold_e                hold_state;
   wdp_hold_e                next_hold_state;
   // Bus slave
   logic                     aw_held;
   logic                     w_held;
   logic [AXI_ADDR_W-1:0]    aw_addr;
   logic [AXI_DATA_W-1:0]    w_data;
   logic [3:0]               w_strb;
   logic                     wr_fire;
   logic                     ar_fire;
   logic                     wr_ctrl;
   logic                     wr_opt;
   logic                     wr_mask;
   logic                     rd_stat;
   logic [AXI_DATA_W-1:0]    rd_word;
   logic                     rd_hit;
   wdp_irq_s                 irq_evt;

   // Terminal count of the shared 8-bit prescaler
   function automatic logic [POST_W-1:0] shared_ratio_last(input wdp_opt_s opt);
      logic [POST_W:0] r;
      r = {{POST_W{1'b0}}, 1'b1} << opt.prescale_rate_field;
      if (!opt.prescaler_assign_bit) begin
         r = r << 1;
      end
      return POST_W'(r - 9'h001);
   endfunction

   // Address match on an aligned word
   function automatic logic addr_is(input logic [AXI_ADDR_W-1:0] a, input logic [7:0] off);
      return a[AXI_ADDR_W-1:2] == off[AXI_ADDR_W-1:2];
   endfunction

   // Enable from the configuration word or software
   assign wdt_enable = config_watchdog_force_on | watchdog_control_reg.software_watchdog_on; // [RL6] [RL7]

   // The oscillator runs while the watchdog or the system clock needs it
   assign lf_run  = wdt_enable | sysclk_on_lfosc;
   assign lf_tick = lf_run & (lf_div_cnt == LF_DIV_W'(LF_DIV - 1));

   // Low-frequency oscillator time base as an enable pulse
   always_ff @(posedge aclk) begin
      if (!aresetn || !lf_run || lf_tick) begin
         lf_div_cnt <= '0;
      end else begin
         lf_div_cnt <= lf_div_cnt + 13'h0001; // [RL1]
      end
   end

   // Stable flag follows only the system clock's use of the oscillator
   always_ff @(posedge aclk) begin
      if (!aresetn || !sysclk_on_lfosc) begin
         lowfreq_stable_flag <= 1'b0;
      end else if (lf_tick) begin
         lowfreq_stable_flag <= 1'b1; // [RL5]
      end
   end

   // Every cause that clears the watchdog count
   assign wdt_clear = ~wdt_enable | clear_watchdog_instr | osc_fail_detect // [RL8]
                    | sleep_exit | (hold_state == WDP_OST_HOLD); // [RL9]

   // Dedicated watchdog prescaler
   wdp_prescaler u_prescaler (
      .aclk         (aclk),
      .aresetn      (aresetn),
      .clear        (wdt_clear),
      .lf_tick      (lf_tick & wdt_enable),
      .prescale_sel (watchdog_control_reg.prescale_sel),
      .count        (pre_count),
      .tick         (pre_tick)
   ); // [RL2] [RL3] [RL10]

   // Shared prescaler routing
   assign shared_last = shared_ratio_last(option_reg);
   assign timeout_evt = option_reg.prescaler_assign_bit
                      ? (pre_tick & (shared_cnt == shared_last))
                      : pre_tick; // [RL11]
   assign t0_evt      = ~option_reg.prescaler_assign_bit & timer0_src_tick
                      & (shared_cnt == shared_last); // [RL11]

   // Shared prescaler counts watchdog ticks or Timer0 source ticks
   always_ff @(posedge aclk) begin
      if (!aresetn || wr_opt) begin
         shared_cnt <= '0;
      end else if (option_reg.prescaler_assign_bit) begin
         if (wdt_clear && !timeout_evt) begin
            shared_cnt <= '0;
         end else if (timeout_evt) begin
            shared_cnt <= '0;
         end else if (pre_tick) begin
            shared_cnt <= shared_cnt + 8'h01; // [RL11]
         end
      end else if (t0_evt) begin
         shared_cnt <= '0;
      end else if (timer0_src_tick) begin
         shared_cnt <= shared_cnt + 8'h01;
      end
   end

   // Timer0 clock, scaled or passed straight through
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timer0_scaled_tick <= 1'b0;
      end else begin
         timer0_scaled_tick <= option_reg.prescaler_assign_bit ? timer0_src_tick : t0_evt; // [RL11]
      end
   end

   // Timeout resets the device when awake and wakes it when asleep
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         watchdog_reset_req <= 1'b0;
         watchdog_wake_req  <= 1'b0;
      end else begin
         watchdog_reset_req <= timeout_evt & ~sleep_active; // [RL10]
         watchdog_wake_req  <= timeout_evt & sleep_active;  // [RL10]
      end
   end

   // Hold after sleep exit in a crystal mode until start-up ends
   always_comb begin
      next_hold_state = hold_state;
      unique case (hold_state)
         WDP_FREE: begin
            if (sleep_exit && sysclk_is_crystal && !osc_startup_done) begin
               next_hold_state = WDP_OST_HOLD; // [RL9]
            end
         end
         WDP_OST_HOLD: begin
            if (osc_startup_done) begin
               next_hold_state = WDP_FREE;
            end
         end
      endcase
   end

   // Hold state register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hold_state <= WDP_FREE;
      end else begin
         hold_state <= next_hold_state;
      end
   end

   // Write channel handshakes
   assign s_axi_awready = ~aw_held;
   assign s_axi_wready  = ~w_held;
   assign wr_fire       = aw_held & w_held & ~s_axi_bvalid;
   assign wr_ctrl       = wr_fire & w_strb[0] & addr_is(aw_addr, REG_WDT_CTRL);
   assign wr_opt        = wr_fire & w_strb[0] & addr_is(aw_addr, REG_OPTION);
   assign wr_mask       = wr_fire & w_strb[0] & addr_is(aw_addr, REG_IRQ_MASK);

   // Capture write address and data in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= '0;
         w_data  <= '0;
         w_strb  <= '0;
      end else begin
         if (s_axi_awvalid && !aw_held) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_held <= 1'b0;
         end
         if (s_axi_wvalid && !w_held) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_held <= 1'b0;
         end
      end
   end

   // Write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (addr_is(aw_addr, REG_WDT_CTRL) || addr_is(aw_addr, REG_OPTION)
                       || addr_is(aw_addr, REG_COUNT) || addr_is(aw_addr, REG_IRQ_STAT)
                       || addr_is(aw_addr, REG_IRQ_MASK) || addr_is(aw_addr, REG_OSC_STAT))
                       ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Control registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         watchdog_control_reg <= CTRL_RESET; // [RL4]
         option_reg           <= OPT_RESET;
         irq_mask             <= IRQ_RESET;
      end else begin
         if (wr_ctrl) begin
            watchdog_control_reg <= wdp_ctrl_s'(w_data[CTRL_W-1:0]);
         end
         if (wr_opt) begin
            option_reg <= wdp_opt_s'(w_data[OPT_W-1:0]);
         end
         if (wr_mask) begin
            irq_mask <= wdp_irq_s'(w_data[IRQ_W-1:0]);
         end
      end
   end

   // Read channel
   assign s_axi_arready = ~s_axi_rvalid;
   assign ar_fire       = s_axi_arvalid & ~s_axi_rvalid;
   assign rd_stat       = ar_fire & addr_is(s_axi_araddr, REG_IRQ_STAT);

   // Read multiplexer
   always_comb begin
      rd_word = '0;
      rd_hit  = 1'b1;
      if (addr_is(s_axi_araddr, REG_WDT_CTRL)) begin
         rd_word[CTRL_W-1:0] = watchdog_control_reg;
      end else if (addr_is(s_axi_araddr, REG_OPTION)) begin
         rd_word[OPT_W-1:0] = option_reg;
      end else if (addr_is(s_axi_araddr, REG_COUNT)) begin
         rd_word[PRE_W+POST_W-1:0] = {shared_cnt, pre_count};
      end else if (addr_is(s_axi_araddr, REG_IRQ_STAT)) begin
         rd_word[IRQ_W-1:0] = irq_stat;
      end else if (addr_is(s_axi_araddr, REG_IRQ_MASK)) begin
         rd_word[IRQ_W-1:0] = irq_mask;
      end else if (addr_is(s_axi_araddr, REG_OSC_STAT)) begin
         rd_word[2:0] = {hold_state == WDP_OST_HOLD, wdt_enable, lowfreq_stable_flag};
      end else begin
         rd_hit = 1'b0;
      end
   end

   // Read data register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= RESP_OKAY;
      end else if (ar_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_word;
         s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Event sources for the sticky status
   assign irq_evt.timeout  = timeout_evt & ~sleep_active;
   assign irq_evt.wake     = timeout_evt & sleep_active;
   assign irq_evt.osc_fail = osc_fail_detect;

   // Sticky status, cleared by a read, a new event wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat <= IRQ_RESET;
      end else begin
         irq_stat <= (rd_stat ? IRQ_RESET : irq_stat) | irq_evt;
      end
   end

   // Interrupt level
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat & irq_mask);
      end
   end

endmodule

/* File: test/watchdog_timer_with_prescaler_tb_top.sv */
`timescale 1ns/1ps
module watchdog_timer_with_prescaler_tb_top;
   import wdp_pkg::*;
   localparam int LFD = 4;
   logic        aclk = 0, aresetn = 0;
   logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = '0;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic        config_watchdog_force_on = 0, clear_watchdog_instr = 0, osc_fail_detect = 0;
   logic        sleep_active = 0, sleep_exit = 0, sysclk_is_crystal = 0, osc_startup_done = 0;
   logic        sysclk_on_lfosc = 0, timer0_src_tick = 0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        watchdog_reset_req, watchdog_wake_req, timer0_scaled_tick, lowfreq_stable_flag, irq;
   int          bad_count = 0, checks = 0, n;
   logic        rs, wk;

   // Free-running system clock
   always #2.5 aclk = ~aclk;

   wdp_watchdog #(.LF_DIV(LFD)) dut (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .config_watchdog_force_on, .clear_watchdog_instr, .osc_fail_detect, .sleep_active, .sleep_exit,
      .sysclk_is_crystal, .osc_startup_done, .sysclk_on_lfosc, .timer0_src_tick, .watchdog_reset_req,
      .watchdog_wake_req, .timer0_scaled_tick, .lowfreq_stable_flag, .irq);

   // Verdict and end of run
   task end_of_test;
      if (bad_count == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // Compare one value
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Bus write; both channels offered together, answer awaited under a bound
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic at, wt, bt, bv;
      int k;
      k = 0;
      bt = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!bt) begin
         @(negedge aclk);
         at = s_axi_awvalid & s_axi_awready;
         wt = s_axi_wvalid & s_axi_wready;
         bv = s_axi_bvalid;
         bt = bv & s_axi_bready;
         if (bt) chk(s_axi_bresp, er);
         k++;
         if (k > 50) begin
            bad_count++;
            end_of_test;
         end
         @(posedge aclk);
         if (at) s_axi_awvalid <= 1'b0;
         if (wt) s_axi_wvalid <= 1'b0;
         s_axi_bready <= bv & !bt;
      end
   endtask

   // Bus read; data and response compared on the handshake
   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic at, rt, rv;
      int k;
      k = 0;
      rt = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      while (!rt) begin
         @(negedge aclk);
         at = s_axi_arvalid & s_axi_arready;
         rv = s_axi_rvalid;
         rt = rv & s_axi_rready;
         if (rt) begin
            chk(s_axi_rdata, ed);
            chk(32'(s_axi_rresp), 32'(er));
         end
         k++;
         if (k > 50) begin
            bad_count++;
            end_of_test;
         end
         @(posedge aclk);
         if (at) s_axi_arvalid <= 1'b0;
         s_axi_rready <= rv & !rt;
      end
   endtask

   // Cycles until a reset or wake request, at most lim
   task automatic meas(input int lim);
      n = 0;
      rs = 0;
      wk = 0;
      while (n < lim && !rs && !wk) begin
         @(negedge aclk);
         n++;
         rs = watchdog_reset_req;
         wk = watchdog_wake_req;
      end
   endtask

   // Reset values, unmapped place, stopped watchdog
   task s_reset;
      rd(REG_WDT_CTRL, 32'h08, RESP_OKAY);
      rd(REG_OPTION, 32'h0F, RESP_OKAY);
      rd(REG_IRQ_MASK, 32'h0, RESP_OKAY);
      rd(REG_IRQ_STAT, 32'h0, RESP_OKAY);
      rd(8'h18, 32'h0, RESP_SLVERR);
      wr(8'h18, 32'h1, RESP_SLVERR);
      wr(REG_OPTION, 32'h08, RESP_OKAY);
      wr(REG_WDT_CTRL, 32'h00, RESP_OKAY);
      meas(400);
      chk(rs | wk, 0);
   endtask

   // Period for select codes 0 to 2, interrupt raise, clear on read, mask, stop
   task s_rates;
      wr(REG_IRQ_MASK, 32'h1, RESP_OKAY);
      for (int s = 0; s < 3; s++) begin
         wr(REG_WDT_CTRL, 32'(s * 2 + 1), RESP_OKAY);
         meas(20000);
         meas(20000);
         chk({rs, n[30:0]}, {1'b1, 31'((32 << s) * LFD)});
      end
      repeat (3) @(negedge aclk);
      chk(irq, 1);
      rd(REG_IRQ_STAT, 32'h1, RESP_OKAY);
      repeat (2) @(negedge aclk);
      chk(irq, 0);
      wr(REG_IRQ_MASK, 32'h0, RESP_OKAY);
      meas(3000);
      repeat (3) @(negedge aclk);
      chk(irq, 0);
      rd(REG_IRQ_STAT, 32'h1, RESP_OKAY);
      wr(REG_WDT_CTRL, 32'h00, RESP_OKAY);
      meas(2000);
      chk(rs | wk, 0);
   endtask

   // Configuration force-on overrides the cleared software bit
   task s_force;
      @(posedge aclk);
      config_watchdog_force_on <= 1'b1;
      meas(300);
      chk(rs, 1);
      @(posedge aclk);
      config_watchdog_force_on <= 1'b0;
      meas(300);
      chk(rs | wk, 0);
   endtask

   // Clear instruction and oscillator failure keep restarting the count
   task s_clear;
      rd(REG_IRQ_STAT, 32'h1, RESP_OKAY);
      wr(REG_WDT_CTRL, 32'h01, RESP_OKAY);
      for (int i = 0; i < 8; i++) begin
         meas(100);
         chk(rs | wk, 0);
         @(posedge aclk);
         if (i < 4) clear_watchdog_instr <= 1'b1;
         else osc_fail_detect <= 1'b1;
         @(posedge aclk);
         clear_watchdog_instr <= 1'b0;
         osc_fail_detect <= 1'b0;
      end
      rd(REG_IRQ_STAT, 32'h4, RESP_OKAY);
   endtask

   // Timeout wakes when asleep; crystal exit holds until start-up ends
   task s_sleep;
      @(posedge aclk);
      sleep_active <= 1'b1;
      meas(300);
      chk({rs, wk}, 2'b01);
      @(posedge aclk);
      sleep_active <= 1'b0;
      sysclk_is_crystal <= 1'b1;
      sleep_exit <= 1'b1;
      @(posedge aclk);
      sleep_exit <= 1'b0;
      meas(400);
      chk(rs | wk, 0);
      rd(REG_OSC_STAT, 32'h6, RESP_OKAY);
      @(posedge aclk);
      osc_startup_done <= 1'b1;
      meas(300);
      chk(rs, 1);
      rd(REG_OSC_STAT, 32'h2, RESP_OKAY);
      @(posedge aclk);
      sysclk_on_lfosc <= 1'b1;
      repeat (20) @(posedge aclk);
      rd(REG_OSC_STAT, 32'h3, RESP_OKAY);
      sysclk_on_lfosc <= 1'b0;
      sysclk_is_crystal <= 1'b0;
   endtask

   // Shared prescaler to Timer0 at two rates, then to the watchdog, while the watchdog keeps its own ratio
   task s_timer0;
      int k, last;
      for (int r = 0; r < 3; r++) begin
         wr(REG_OPTION, (r == 2) ? 32'h8 : 32'(r), RESP_OKAY);
         k = 0;
         last = -1;
         for (int i = 0; i < 304; i++) begin
            @(posedge aclk);
            timer0_src_tick <= (i < 300);
            @(negedge aclk);
            k += timer0_scaled_tick;
            if (watchdog_reset_req) begin
               if (last >= 0) chk(i - last, 32 * LFD);
               last = i;
            end
         end
         chk(k, (r == 2) ? 300 : 300 >> (r + 1));
      end
   endtask

   // Main sequence
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      s_reset;
      s_rates;
      s_force;
      s_clear;
      s_sleep;
      s_timer0;
      end_of_test;
   end
endmodule

/* File: test/wdp_watchdog_assertions.sv */
`timescale 1ns/1ps
module wdp_watchdog_checker #(
   parameter int unsigned LF_DIV = 4
) (
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Bus answers
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // Core events
   input wire logic        clear_watchdog_instr,
   input wire logic        osc_fail_detect,
   input wire logic        sleep_active,
   input wire logic        sleep_exit,
   input wire logic        sysclk_is_crystal,
   input wire logic        osc_startup_done,
   input wire logic        sysclk_on_lfosc,
   // Results
   input wire logic        watchdog_reset_req,
   input wire logic        watchdog_wake_req,
   input wire logic        lowfreq_stable_flag
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   int unsigned since_clr;

   // Cycles since the count was last cleared by an event
   always_ff @(posedge aclk) begin
      if (!aresetn || clear_watchdog_instr || osc_fail_detect || sleep_exit) begin
         since_clr <= 0;
      end else if (since_clr < 32'd1000000) begin
         since_clr <= since_clr + 1;
      end
   end

   // Sleep exit on a crystal clock with the start-up timer still running
   sequence hold_entered;
      sleep_exit && sysclk_is_crystal && !osc_startup_done;
   endsequence
   sequence hold_kept;
      (!osc_startup_done && !sleep_exit)[*3];
   endsequence

   chk_min_period: assert property ((watchdog_reset_req || watchdog_wake_req) |->
      (since_clr == 0 || since_clr >= 31 * LF_DIV + 1))
      else $error("timeout sooner than the shortest ratio after a clear");
   chk_reset_spacing: assert property (watchdog_reset_req |=> !watchdog_reset_req[*8])
      else $error("reset request repeated too soon");
   chk_wake_asleep: assert property (watchdog_wake_req |-> $past(sleep_active))
      else $error("wake request while awake");
   chk_reset_awake: assert property (watchdog_reset_req |-> !$past(sleep_active))
      else $error("reset request while asleep");
   chk_stable_off: assert property ((!sysclk_on_lfosc)[*2] |-> !lowfreq_stable_flag)
      else $error("stable flag set without the system clock on the oscillator");
   chk_hold_quiet: assert property (hold_entered ##1 hold_kept |->
      !watchdog_reset_req && !watchdog_wake_req)
      else $error("timeout while held after sleep exit");
   chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped or changed before taken");
   chk_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped or changed before taken");
endmodule

bind wdp_watchdog wdp_watchdog_checker #(.LF_DIV(LF_DIV)) u_chk (
   .aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .s_axi_rready,
   .s_axi_rdata, .clear_watchdog_instr, .osc_fail_detect, .sleep_active, .sleep_exit,
   .sysclk_is_crystal, .osc_startup_done, .sysclk_on_lfosc, .watchdog_reset_req,
   .watchdog_wake_req, .lowfreq_stable_flag);
